// file: elpc_defs.vh
/*
 Constants for the exchange-side path control state machine:
 state codes, message codes, management command codes, timer lengths.
 Assumes inclusion by the path control modules, the checker, the peer model and the bench.
*/
`ifndef ELPC_DEFS_VH
`define ELPC_DEFS_VH

// Protocol states
`define ELPC_ST_OUT_OF_SERVICE 3'h0
`define ELPC_ST_NULL 3'h1
`define ELPC_ST_PATH_INIT_LOCAL 3'h2
`define ELPC_ST_PATH_INIT_PEER 3'h3
`define ELPC_ST_PATH_ACTIVE 3'h4
`define ELPC_ST_DISCONNECT_REQUEST 3'h5
`define ELPC_ST_PORT_BLOCKED 3'h6

// Outgoing message codes
`define ELPC_MSG_NONE 4'h0
`define ELPC_MSG_ESTABLISH 4'h1
`define ELPC_MSG_DISCONNECT 4'h2
`define ELPC_MSG_DISC_COMPLETE 4'h3
`define ELPC_MSG_STATUS_ENQUIRY 4'h4
`define ELPC_MSG_SIGNAL_ACK 4'h5
`define ELPC_MSG_PARAMETER 4'h6

// Management control commands
`define ELPC_MGT_NONE 3'h0
`define ELPC_MGT_BLOCK 3'h1
`define ELPC_MGT_UNBLOCK 3'h2
`define ELPC_MGT_RESTART_REQ 3'h3
`define ELPC_MGT_RESTART_DONE 3'h4

// Timer lengths in milliseconds, sized to the default timer width
`define ELPC_T1_MS 16'h0FA0
`define ELPC_T3_MS 16'h07D0
`define ELPC_T4_MS 16'h0708
`define ELPC_TR_MS 16'h0064
`define ELPC_TT_MS 16'h07D0
// Cycles per millisecond at 10 MHz
`define ELPC_MS_CYCLES 16'h2710

// Retry limits
`define ELPC_T1_LIMIT 2'd2
`define ELPC_T3_LIMIT 2'd3
`define ELPC_T4_LIMIT 2'd3

`endif

// file: elpc_timer.v
/*
 One protocol timer: start or restart, stop, one-cycle expiry pulse.
 Assumes a one-cycle millisecond tick from the parent's divider.
*/
`include "elpc_defs.vh"

module elpc_timer #(
	parameter W = 16
) (
	input wire clk,
	input wire rstn,
	input wire tick_ms,
	input wire start,
	input wire stop,
	input wire [W-1:0] length,
	output reg running_q,
	output reg expired_q
);

reg [W-1:0] count_q;

////////////////////////////////////////////////////////////////////////////////
// Start wins over stop so a restart in a stopping cycle holds
always @(posedge clk) begin
	if (!rstn) begin
		running_q <= 1'b0;
		count_q <= {W{1'b0}};
		expired_q <= 1'b0;
	end else begin
		expired_q <= 1'b0;
		if (start) begin
			running_q <= 1'b1;
			count_q <= length;
		end else if (stop) begin
			running_q <= 1'b0;
		end else if (running_q && tick_ms) begin
			if (count_q <= {{(W-1){1'b0}}, 1'b1}) begin
				running_q <= 1'b0;
				expired_q <= 1'b1;
			end else begin
				count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
end

endmodule

// file: elpc_path_ctrl.v
/*
 Exchange-side path control state machine for one analogue user port:
 local requests, management commands, timer expiries, status checks.
 Assumes all request inputs are one-cycle pulses from logic on clk;
 one event is handled per cycle with a fixed priority.
*/
// Summary of operation
// - Parameter request sends message in active state
// - No sequence number: send, then disconnect
// - Disconnect-complete request clears initiated states
// - Block moves anywhere to blocked; unblock
// - Establish timer: retry once, then disconnect
// - Disconnect timer resends; third expiry errors
// - Status timer resends; third expiry errors
// - Status timer stops on answer or with all timers
// - Incompatible peer state outside disconnect request forces error; disconnect unless out of service or blocked
// - Receive-ack timer started once; sends acknowledge
// - Bad received sequence number in active state forces disconnect
// - Disconnect complete only after pending signalling action finishes
`include "elpc_defs.vh"

module elpc_path_ctrl #(
	parameter TW = 16,
	parameter [TW-1:0] T1_MS = `ELPC_T1_MS,
	parameter [TW-1:0] T3_MS = `ELPC_T3_MS,
	parameter [TW-1:0] T4_MS = `ELPC_T4_MS,
	parameter [TW-1:0] TR_MS = `ELPC_TR_MS,
	parameter [TW-1:0] TT_MS = `ELPC_TT_MS,
	parameter [15:0] MS_CYCLES = `ELPC_MS_CYCLES
) (
	input wire clk,
	input wire rstn,
	input wire local_parameter_send_request,
	input wire seq_unavailable,
	input wire local_disconnect_request,
	input wire local_disconnect_done_request,
	input wire establish_start,
	input wire establish_ack_received,
	input wire [2:0] management_control_command,
	input wire status_received,
	input wire status_is_answer,
	input wire [2:0] peer_state,
	input wire signal_received,
	input wire signal_ack_received,
	input wire rx_seq_invalid,
	input wire ack_pending_action,
	input wire action_done,
	output reg [3:0] tx_msg_q,
	output reg tx_valid_q,
	output reg management_error_indication,
	output reg upward_disconnect_complete_indication,
	output reg restart_ack_q,
	output reg clear_port_q,
	output reg [2:0] state_q
);

reg [15:0] div_q;
reg tick_q;
reg [1:0] t1_cnt_q;
reg [1:0] t3_cnt_q;
reg [1:0] t4_cnt_q;
reg ack_hold_q;
reg disc_pend_q;
reg [2:0] state_d;
reg [3:0] msg_d;
reg err_d, upind_d, rack_d, clr_d, stop_all, stop_t4;
reg stop_t1, pend_set, pend_d;
reg st1, st3, st4, str, stt;
wire t1_run, t3_run, t4_run, tr_run, tt_run;
wire t1_exp, t3_exp, t4_exp, tr_exp, tt_exp;
wire [2:0] ev_state;

////////////////////////////////////////////////////////////////////////////////
// Compatible states: peer reports the same path phase
function compat;
	input [2:0] own;
	input [2:0] peer;
	begin
		if (own == `ELPC_ST_PATH_INIT_LOCAL || own == `ELPC_ST_PATH_INIT_PEER)
			compat = (peer == `ELPC_ST_PATH_INIT_LOCAL) || (peer == `ELPC_ST_PATH_INIT_PEER);
		else
			compat = (peer == own);
	end
endfunction

// Initiated, active or disconnect states
function in_path;
	input [2:0] s;
	begin
		in_path = (s >= `ELPC_ST_PATH_INIT_LOCAL) && (s <= `ELPC_ST_DISCONNECT_REQUEST);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Millisecond tick from a divider
always @(posedge clk) begin
	if (!rstn) begin
		div_q <= 16'h0000;
		tick_q <= 1'b0;
	end else if (div_q == MS_CYCLES - 16'h0001) begin
		div_q <= 16'h0000;
		tick_q <= 1'b1;
	end else begin
		div_q <= div_q + 16'h0001;
		tick_q <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Event decision, one event per cycle, management first
always @* begin
	state_d = state_q;
	msg_d = `ELPC_MSG_NONE;
	err_d = 1'b0;
	upind_d = 1'b0;
	rack_d = 1'b0;
	clr_d = 1'b0;
	stop_all = 1'b0;
	stop_t4 = 1'b0;
	stop_t1 = 1'b0;
	pend_set = 1'b0;
	st1 = 1'b0;
	st3 = 1'b0;
	st4 = 1'b0;
	str = 1'b0;
	stt = 1'b0;
	if (management_control_command == `ELPC_MGT_BLOCK) begin
		if (state_q != `ELPC_ST_PORT_BLOCKED) begin
			state_d = `ELPC_ST_PORT_BLOCKED;
			if (in_path(state_q)) begin
				stop_all = 1'b1;
				msg_d = `ELPC_MSG_DISC_COMPLETE;
				upind_d = 1'b1;
			end else if (state_q == `ELPC_ST_NULL) begin
				stop_all = 1'b1;
				clr_d = 1'b1;
				upind_d = 1'b1;
			end
		end
	end else if (management_control_command == `ELPC_MGT_UNBLOCK) begin
		if (state_q == `ELPC_ST_PORT_BLOCKED)
			state_d = `ELPC_ST_NULL;
	end else if (management_control_command == `ELPC_MGT_RESTART_REQ) begin
		rack_d = 1'b1;
		if (state_q == `ELPC_ST_NULL || in_path(state_q)) begin
			msg_d = `ELPC_MSG_DISC_COMPLETE;
			upind_d = 1'b1;
			clr_d = (state_q == `ELPC_ST_NULL);
			stop_all = 1'b1;
			state_d = `ELPC_ST_OUT_OF_SERVICE;
		end
	end else if (management_control_command == `ELPC_MGT_RESTART_DONE) begin
		if (state_q == `ELPC_ST_OUT_OF_SERVICE)
			state_d = `ELPC_ST_NULL;
	end else if (status_received && state_q != `ELPC_ST_DISCONNECT_REQUEST) begin
		stop_t4 = status_is_answer;
		if (!compat(state_q, peer_state)) begin
			err_d = 1'b1;
			if (state_q != `ELPC_ST_OUT_OF_SERVICE && state_q != `ELPC_ST_PORT_BLOCKED) begin
				stop_all = 1'b1;
				msg_d = `ELPC_MSG_DISCONNECT;
				st3 = 1'b1;
				state_d = `ELPC_ST_DISCONNECT_REQUEST;
			end
		end
	end else if ((signal_received || signal_ack_received)
			&& state_q != `ELPC_ST_DISCONNECT_REQUEST) begin
		if (state_q != `ELPC_ST_PATH_ACTIVE) begin
			// Signalling out of place: ask the peer for its state
			msg_d = `ELPC_MSG_STATUS_ENQUIRY;
			st4 = 1'b1;
		end else if (rx_seq_invalid) begin
			stop_all = 1'b1;
			err_d = 1'b1;
			msg_d = `ELPC_MSG_DISCONNECT;
			st3 = 1'b1;
			state_d = `ELPC_ST_DISCONNECT_REQUEST;
		end else if (signal_received) begin
			str = !tr_run;
		end
	end else if (local_parameter_send_request && state_q == `ELPC_ST_PATH_ACTIVE) begin
		msg_d = `ELPC_MSG_PARAMETER;
		if (seq_unavailable) begin
			stop_all = 1'b1;
			err_d = 1'b1;
			st3 = 1'b1;
			pend_set = 1'b1;
			state_d = `ELPC_ST_DISCONNECT_REQUEST;
		end else begin
			stt = 1'b1;
		end
	end else if (local_disconnect_request && (in_path(state_q))
			&& state_q != `ELPC_ST_DISCONNECT_REQUEST) begin
		stop_all = 1'b1;
		msg_d = `ELPC_MSG_DISCONNECT;
		st3 = 1'b1;
		state_d = `ELPC_ST_DISCONNECT_REQUEST;
	end else if (local_disconnect_done_request && (state_q == `ELPC_ST_PATH_INIT_LOCAL
			|| state_q == `ELPC_ST_PATH_INIT_PEER)) begin
		stop_all = (state_q == `ELPC_ST_PATH_INIT_LOCAL);
		msg_d = `ELPC_MSG_DISC_COMPLETE;
		state_d = `ELPC_ST_NULL;
	end else if (establish_start && state_q == `ELPC_ST_NULL) begin
		msg_d = `ELPC_MSG_ESTABLISH;
		st1 = 1'b1;
		state_d = `ELPC_ST_PATH_INIT_LOCAL;
	end else if (establish_ack_received && state_q == `ELPC_ST_PATH_INIT_LOCAL) begin
		// Peer acknowledged our establish: path goes active
		stop_t1 = 1'b1;
		state_d = `ELPC_ST_PATH_ACTIVE;
	end else if (t1_exp && state_q == `ELPC_ST_PATH_INIT_LOCAL) begin
		if (t1_cnt_q == `ELPC_T1_LIMIT - 2'd1) begin
			st3 = 1'b1;
			msg_d = `ELPC_MSG_DISCONNECT;
			err_d = 1'b1;
			state_d = `ELPC_ST_DISCONNECT_REQUEST;
		end else begin
			msg_d = `ELPC_MSG_ESTABLISH;
			st1 = 1'b1;
		end
	end else if (t3_exp && state_q == `ELPC_ST_DISCONNECT_REQUEST) begin
		err_d = (t3_cnt_q == `ELPC_T3_LIMIT - 2'd1);
		msg_d = `ELPC_MSG_DISCONNECT;
		st3 = 1'b1;
	end else if (t4_exp && state_q != `ELPC_ST_DISCONNECT_REQUEST) begin
		msg_d = `ELPC_MSG_STATUS_ENQUIRY;
		st4 = 1'b1;
		if (t4_cnt_q == `ELPC_T4_LIMIT - 2'd1) begin
			err_d = 1'b1;
			if (state_q >= `ELPC_ST_NULL && state_q <= `ELPC_ST_PATH_ACTIVE) begin
				st4 = 1'b0;
				stop_all = 1'b1;
				msg_d = `ELPC_MSG_DISCONNECT;
				st3 = 1'b1;
				state_d = `ELPC_ST_DISCONNECT_REQUEST;
			end
		end
	end else if (tr_exp && state_q == `ELPC_ST_PATH_ACTIVE) begin
		msg_d = `ELPC_MSG_SIGNAL_ACK;
	end else if (tt_exp && state_q == `ELPC_ST_PATH_ACTIVE) begin
		stop_all = 1'b1;
		err_d = 1'b1;
		msg_d = `ELPC_MSG_DISCONNECT;
		st3 = 1'b1;
		state_d = `ELPC_ST_DISCONNECT_REQUEST;
	end
	// Owed disconnect takes the next free message slot; dropped once the state moves on
	pend_d = pend_set || (disc_pend_q && msg_d != `ELPC_MSG_NONE
		&& msg_d != `ELPC_MSG_DISCONNECT && state_d == `ELPC_ST_DISCONNECT_REQUEST);
	if (disc_pend_q && msg_d == `ELPC_MSG_NONE && state_q == `ELPC_ST_DISCONNECT_REQUEST)
		msg_d = `ELPC_MSG_DISCONNECT;
end

assign ev_state = state_d;

////////////////////////////////////////////////////////////////////////////////
// Registered outputs, retry counters, held acknowledge
always @(posedge clk) begin
	if (!rstn) begin
		state_q <= `ELPC_ST_NULL;
		tx_msg_q <= `ELPC_MSG_NONE;
		tx_valid_q <= 1'b0;
		management_error_indication <= 1'b0;
		upward_disconnect_complete_indication <= 1'b0;
		restart_ack_q <= 1'b0;
		clear_port_q <= 1'b0;
		t1_cnt_q <= 2'd0;
		t3_cnt_q <= 2'd0;
		t4_cnt_q <= 2'd0;
		ack_hold_q <= 1'b0;
		disc_pend_q <= 1'b0;
	end else begin
		state_q <= ev_state;
		disc_pend_q <= pend_d;
		management_error_indication <= err_d;
		upward_disconnect_complete_indication <= upind_d;
		restart_ack_q <= rack_d;
		clear_port_q <= clr_d;
		// A disconnect complete waits for the signalling action to finish
		if (msg_d == `ELPC_MSG_DISC_COMPLETE && ack_pending_action && !action_done) begin
			ack_hold_q <= 1'b1;
			tx_msg_q <= `ELPC_MSG_NONE;
			tx_valid_q <= 1'b0;
		end else if (ack_hold_q && action_done) begin
			ack_hold_q <= 1'b0;
			tx_msg_q <= `ELPC_MSG_DISC_COMPLETE;
			tx_valid_q <= 1'b1;
		end else begin
			tx_msg_q <= msg_d;
			tx_valid_q <= (msg_d != `ELPC_MSG_NONE);
		end
		// Expiry counts reset when the timer is freshly started
		if (stop_all || (st1 && !t1_exp))
			t1_cnt_q <= 2'd0;
		else if (t1_exp && st1)
			t1_cnt_q <= t1_cnt_q + 2'd1;
		if (ev_state != `ELPC_ST_DISCONNECT_REQUEST || (st3 && !t3_exp))
			t3_cnt_q <= 2'd0;
		else if (t3_exp)
			t3_cnt_q <= (t3_cnt_q == `ELPC_T3_LIMIT - 2'd1) ? 2'd0 : t3_cnt_q + 2'd1;
		if (stop_all || stop_t4 || (st4 && !t4_exp))
			t4_cnt_q <= 2'd0;
		else if (t4_exp && st4)
			t4_cnt_q <= (t4_cnt_q == `ELPC_T4_LIMIT - 2'd1) ? 2'd0 : t4_cnt_q + 2'd1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// The five protocol timers
elpc_timer #(.W(TW)) u_t1 (.clk(clk), .rstn(rstn), .tick_ms(tick_q), .start(st1),
	.stop(stop_all | stop_t1), .length(T1_MS), .running_q(t1_run), .expired_q(t1_exp));
elpc_timer #(.W(TW)) u_t3 (.clk(clk), .rstn(rstn), .tick_ms(tick_q), .start(st3),
	.stop(stop_all), .length(T3_MS), .running_q(t3_run), .expired_q(t3_exp));
elpc_timer #(.W(TW)) u_t4 (.clk(clk), .rstn(rstn), .tick_ms(tick_q), .start(st4),
	.stop(stop_all | stop_t4), .length(T4_MS), .running_q(t4_run), .expired_q(t4_exp));
elpc_timer #(.W(TW)) u_tr (.clk(clk), .rstn(rstn), .tick_ms(tick_q), .start(str),
	.stop(stop_all), .length(TR_MS), .running_q(tr_run), .expired_q(tr_exp));
elpc_timer #(.W(TW)) u_tt (.clk(clk), .rstn(rstn), .tick_ms(tick_q), .start(stt),
	.stop(stop_all), .length(TT_MS), .running_q(tt_run), .expired_q(tt_exp));

endmodule

// file: elpc_path_ctrl_asserts.sv
/*
 Checker bound to the path control top.
 Assumes the defs header and a single clock domain.
*/
`include "elpc_defs.vh"
module elpc_path_ctrl_asserts (
	input wire clk,
	input wire rstn,
	input wire local_parameter_send_request,
	input wire seq_unavailable,
	input wire local_disconnect_request,
	input wire local_disconnect_done_request,
	input wire [2:0] management_control_command,
	input wire status_received,
	input wire signal_received,
	input wire signal_ack_received,
	input wire ack_pending_action,
	input wire [3:0] tx_msg_q,
	input wire tx_valid_q,
	input wire management_error_indication,
	input wire restart_ack_q,
	input wire clear_port_q,
	input wire [2:0] state_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	////////////////////////////////////////
	// Nothing of higher priority, so a local request is taken
	wire [2:0] cmd = management_control_command;
	wire quiet = cmd == `ELPC_MGT_NONE && !status_received && !signal_received &&
		!signal_ack_received;
	wire prm = local_parameter_send_request && quiet && state_q == `ELPC_ST_PATH_ACTIVE;
	wire dsc = local_disconnect_request && quiet && !local_parameter_send_request;
	wire don = local_disconnect_done_request && quiet && !local_parameter_send_request &&
		!local_disconnect_request && !ack_pending_action;
	////////////////////////////////////////
	a_param_sent: assert property (
		prm |=> tx_valid_q && tx_msg_q == `ELPC_MSG_PARAMETER) else $error("no parameter");
	a_noseq_disc: assert property (
		prm && seq_unavailable |=> management_error_indication &&
		state_q == `ELPC_ST_DISCONNECT_REQUEST) else $error("no seq not handled");
	a_done_init: assert property (
		don && state_q == `ELPC_ST_PATH_INIT_LOCAL |=> tx_msg_q == `ELPC_MSG_DISC_COMPLETE &&
		state_q == `ELPC_ST_NULL) else $error("done request not handled");
	a_local_disc: assert property (
		dsc && state_q >= `ELPC_ST_PATH_INIT_LOCAL && state_q <= `ELPC_ST_PATH_ACTIVE |=>
		tx_msg_q == `ELPC_MSG_DISCONNECT && state_q == `ELPC_ST_DISCONNECT_REQUEST)
		else $error("disconnect not started");
	a_block_any: assert property (
		cmd == `ELPC_MGT_BLOCK |=> state_q == `ELPC_ST_PORT_BLOCKED) else $error("not blocked");
	a_block_clear: assert property (
		cmd == `ELPC_MGT_BLOCK && state_q == `ELPC_ST_NULL |=> clear_port_q)
		else $error("port not cleared");
	a_unblock_null: assert property (
		cmd == `ELPC_MGT_UNBLOCK && state_q == `ELPC_ST_PORT_BLOCKED |=> state_q == `ELPC_ST_NULL)
		else $error("unblock failed");
	a_restart_ack: assert property (
		cmd == `ELPC_MGT_RESTART_REQ |=> restart_ack_q) else $error("no restart ack");
	a_error_state: assert property (
		management_error_indication |-> state_q inside {`ELPC_ST_OUT_OF_SERVICE,
		`ELPC_ST_DISCONNECT_REQUEST, `ELPC_ST_PORT_BLOCKED}) else $error("error in bad state");
	// Main scenarios reached
	c_disc: cover property (state_q == `ELPC_ST_DISCONNECT_REQUEST ##1 management_error_indication);
	c_oos: cover property (restart_ack_q && state_q == `ELPC_ST_OUT_OF_SERVICE);
	c_clear: cover property (clear_port_q);
endmodule
bind elpc_path_ctrl elpc_path_ctrl_asserts chk_u (.clk, .rstn, .local_parameter_send_request,
	.seq_unavailable, .local_disconnect_request, .local_disconnect_done_request,
	.management_control_command, .status_received, .signal_received, .signal_ack_received,
	.ack_pending_action, .tx_msg_q, .tx_valid_q, .management_error_indication, .restart_ack_q,
	.clear_port_q, .state_q);

// file: elpc_peer_model.sv
/*
 Peer entity model: answers status enquiries and injected reports.
 Assumes the bench clock; one answer at a time; mute silences enquiry answers.
*/
`include "elpc_defs.vh"
module elpc_peer_model (
	input wire clk,
	input wire [3:0] tx_msg_q,
	input wire tx_valid_q,
	input wire inj,
	input wire [2:0] inj_state,
	input wire mute,
	output logic status_received,
	output logic status_is_answer,
	output logic [2:0] peer_state
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		status_received = 1'b0;
		status_is_answer = 1'b0;
		peer_state = 3'h5;
	end
	// Answer after 0..2 cycles; never signals, so no metering report
	always @(posedge clk) begin
		logic hit;
		logic [2:0] st;
		hit = inj;
		st = inj_state;
		if (hit || (!mute && tx_valid_q && tx_msg_q == `ELPC_MSG_STATUS_ENQUIRY)) begin
			repeat ($urandom_range(2)) @(posedge clk);
			status_received <= 1'b1;
			status_is_answer <= !hit;
			peer_state <= hit ? st : `ELPC_ST_NULL;
			@(posedge clk);
		end
		// Idle qualifiers wander so a stale value is never trusted
		status_received <= 1'b0;
		status_is_answer <= ~status_is_answer;
		peer_state <= ~peer_state;
	end
endmodule

// file: test_elpc_path_ctrl.sv
/*
 Self-checking bench for the path control state machine.
 Assumes the defs header and a two-cycle millisecond tick.
*/
`include "elpc_defs.vh"
module test_elpc_path_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [10:0] ev = 11'h000;
	logic [2:0] mg = 3'h0;
	logic [2:0] ist = 3'h1;
	logic apa = 1'b0;
	logic mu = 1'b0;
	wire [3:0] tx_msg_q;
	wire [2:0] state_q, ps;
	wire tx_valid_q, err, up, clr, ack, sr, sa;
	int n_fail = 0;
	int n_tests = 0;
	always #50 clk = ~clk;
	////////////////////////////////////////
	elpc_path_ctrl #(.MS_CYCLES(16'h0002)) dut_u (.clk, .rstn,
		.local_parameter_send_request(ev[0]), .seq_unavailable(ev[7]),
		.local_disconnect_request(ev[1]), .local_disconnect_done_request(ev[2]),
		.establish_start(ev[3]), .establish_ack_received(ev[6]),
		.management_control_command(mg), .status_received(sr),
		.status_is_answer(sa), .peer_state(ps), .signal_received(ev[8]),
		.signal_ack_received(ev[10]), .rx_seq_invalid(ev[9]), .ack_pending_action(apa),
		.action_done(ev[5]), .tx_msg_q, .tx_valid_q, .management_error_indication(err),
		.upward_disconnect_complete_indication(up), .restart_ack_q(ack), .clear_port_q(clr),
		.state_q);
	elpc_peer_model pm_u (.clk, .tx_msg_q, .tx_valid_q, .inj(ev[4]), .inj_state(ist), .mute(mu),
		.status_received(sr), .status_is_answer(sa), .peer_state(ps));
	////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Flags are {upward, clear, ack}; state 7 means any state
	task automatic chk(input [3:0] m, input e, input [2:0] f, input [2:0] s);
		n_tests++;
		if (tx_valid_q !== (m != 4'h0) || (m != 4'h0 && tx_msg_q !== m) || err !== e ||
			{up, clr, ack} !== f || (s != 3'h7 && state_q !== s)) begin
			n_fail++;
			$display("wrong value outputs expected %h %b %b %h seen %b %h %b %b %h", m, e, f, s,
				tx_valid_q, tx_msg_q, err, {up, clr, ack}, state_q);
		end
	endtask
	// Event sampled at one edge; the next call or wait replaces it
	task automatic go(input [10:0] e, input [2:0] c, input [3:0] m, input r, input [2:0] f,
		input [2:0] s);
		ev = e;
		mg = c;
		@(posedge clk);
		#10;
		chk(m, r, f, s);
	endtask
	// Bounded wait for the next message, then compare
	task automatic wt(input [3:0] m, input r, input [2:0] s);
		int i;
		i = 0;
		ev = 11'h000;
		mg = 3'h0;
		do begin
			@(posedge clk);
			#10;
			i++;
		end while (tx_valid_q !== 1'b1 && i < 10000);
		if (tx_valid_q !== 1'b1) begin
			n_fail++;
			$display("wrong value tx_valid_q expected 1 seen %b", tx_valid_q);
			summarize();
		end
		chk(m, r, 3'h0, s);
	endtask
	task automatic blk(input [3:0] m, input [2:0] f);
		go(0, `ELPC_MGT_BLOCK, m, 0, f, `ELPC_ST_PORT_BLOCKED);
		go(0, `ELPC_MGT_UNBLOCK, 0, 0, 0, `ELPC_ST_NULL);
	endtask
	// Establish, then the peer's acknowledge makes the path active
	task automatic act();
		go(6'h08, 0, `ELPC_MSG_ESTABLISH, 0, 0, `ELPC_ST_PATH_INIT_LOCAL);
		go(11'h040, 0, 0, 0, 0, `ELPC_ST_PATH_ACTIVE);
	endtask
	////////////////////////////////////////
	initial begin
		void'($urandom(32'hF751A6BD));
		repeat (2) @(posedge clk);
		#10;
		rstn = 1'b1;
		go(0, 0, 0, 0, 0, `ELPC_ST_NULL);
		// Parameter request ignored outside the active state
		go(6'h01, 0, 0, 0, 0, `ELPC_ST_NULL);
		go(0, `ELPC_MGT_BLOCK, 0, 0, 3'h6, `ELPC_ST_PORT_BLOCKED);
		go(6'h01, 0, 0, 0, 0, `ELPC_ST_PORT_BLOCKED);
		go(0, `ELPC_MGT_UNBLOCK, 0, 0, 0, `ELPC_ST_NULL);
		// Restart, restart again while out of service, then complete
		go(0, `ELPC_MGT_RESTART_REQ, `ELPC_MSG_DISC_COMPLETE, 0, 3'h7, 0);
		go(0, `ELPC_MGT_RESTART_REQ, 0, 0, 3'h1, `ELPC_ST_OUT_OF_SERVICE);
		go(0, `ELPC_MGT_RESTART_DONE, 0, 0, 0, `ELPC_ST_NULL);
		$display("test management done");
		go(6'h08, 0, `ELPC_MSG_ESTABLISH, 0, 0, `ELPC_ST_PATH_INIT_LOCAL);
		go(6'h04, 0, `ELPC_MSG_DISC_COMPLETE, 0, 0, `ELPC_ST_NULL);
		go(6'h08, 0, `ELPC_MSG_ESTABLISH, 0, 0, `ELPC_ST_PATH_INIT_LOCAL);
		go(6'h02, 0, `ELPC_MSG_DISCONNECT, 0, 0, `ELPC_ST_DISCONNECT_REQUEST);
		go(6'h06, 0, 0, 0, 0, `ELPC_ST_DISCONNECT_REQUEST);
		blk(`ELPC_MSG_DISC_COMPLETE, 3'h4);
		// Completion held back while a signalling action runs
		apa = 1'b1;
		go(6'h08, 0, `ELPC_MSG_ESTABLISH, 0, 0, `ELPC_ST_PATH_INIT_LOCAL);
		go(6'h04, 0, 0, 0, 0, 3'h7);
		go(6'h20, 0, `ELPC_MSG_DISC_COMPLETE, 0, 0, `ELPC_ST_NULL);
		apa = 1'b0;
		$display("test local done");
		// Active path: parameter, receive acknowledge, transmit timeout
		act();
		go(6'h01, 0, `ELPC_MSG_PARAMETER, 0, 0, `ELPC_ST_PATH_ACTIVE);
		go(11'h100, 0, 0, 0, 0, `ELPC_ST_PATH_ACTIVE);
		wt(`ELPC_MSG_SIGNAL_ACK, 0, `ELPC_ST_PATH_ACTIVE);
		wt(`ELPC_MSG_DISCONNECT, 1, `ELPC_ST_DISCONNECT_REQUEST);
		blk(`ELPC_MSG_DISC_COMPLETE, 3'h4);
		// No sequence number: parameter still sent, disconnect follows
		act();
		go(11'h081, 0, `ELPC_MSG_PARAMETER, 1, 0, `ELPC_ST_DISCONNECT_REQUEST);
		go(0, 0, `ELPC_MSG_DISCONNECT, 0, 0, `ELPC_ST_DISCONNECT_REQUEST);
		blk(`ELPC_MSG_DISC_COMPLETE, 3'h4);
		act();
		go(11'h600, 0, `ELPC_MSG_DISCONNECT, 1, 0, `ELPC_ST_DISCONNECT_REQUEST);
		blk(`ELPC_MSG_DISC_COMPLETE, 3'h4);
		$display("test active done");
		// Silent peer: enquiry repeats twice, third expiry disconnects
		mu = 1'b1;
		go(11'h100, 0, `ELPC_MSG_STATUS_ENQUIRY, 0, 0, `ELPC_ST_NULL);
		for (int k = 1; k <= 2; k++)
			wt(`ELPC_MSG_STATUS_ENQUIRY, 0, `ELPC_ST_NULL);
		wt(`ELPC_MSG_DISCONNECT, 1, `ELPC_ST_DISCONNECT_REQUEST);
		mu = 1'b0;
		blk(`ELPC_MSG_DISC_COMPLETE, 3'h4);
		// Answered enquiry: compatible, timer stopped, so the waits below see no enquiry
		go(11'h100, 0, `ELPC_MSG_STATUS_ENQUIRY, 0, 0, `ELPC_ST_NULL);
		repeat (4) go(0, 0, 0, 0, 0, `ELPC_ST_NULL);
		// Establish timer retries once, then disconnect timer three times
		go(6'h08, 0, `ELPC_MSG_ESTABLISH, 0, 0, `ELPC_ST_PATH_INIT_LOCAL);
		wt(`ELPC_MSG_ESTABLISH, 0, `ELPC_ST_PATH_INIT_LOCAL);
		wt(`ELPC_MSG_DISCONNECT, 1, `ELPC_ST_DISCONNECT_REQUEST);
		for (int k = 1; k <= 3; k++)
			wt(`ELPC_MSG_DISCONNECT, k == 3, `ELPC_ST_DISCONNECT_REQUEST);
		blk(`ELPC_MSG_DISC_COMPLETE, 3'h4);
		// Peer reports a state that cannot match idle
		ist = 3'($urandom_range(6, 2));
		go(6'h10, 0, 0, 0, 0, `ELPC_ST_NULL);
		wt(`ELPC_MSG_DISCONNECT, 1, `ELPC_ST_DISCONNECT_REQUEST);
		blk(`ELPC_MSG_DISC_COMPLETE, 3'h4);
		$display("test timers done");
		summarize();
	end
endmodule
